/* hw/pcg_consts.svh */
// offsets, field positions and reset values of the peripheral clock gating block
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

// ==========================================
// register byte offsets
`define PCG_OFF_RUN1 12'h104
`define PCG_OFF_RUN2 12'h108
`define PCG_OFF_SLP1 12'h114
`define PCG_OFF_SLP2 12'h118
`define PCG_OFF_DSL1 12'h124
`define PCG_OFF_DSL2 12'h128
`define PCG_OFF_RCC 12'h060
`define PCG_OFF_FSTAT 12'h200
`define PCG_OFF_FMASK 12'h204

// ==========================================
// field positions and masks
`define PCG_G1_COMPARATOR_ZERO_GATE 24
`define PCG_G1_TMR2 18
`define PCG_G1_TMR1 17
`define PCG_G1_TMR0 16
`define PCG_G1_SYNC_SERIAL_ZERO_GATE 4
`define PCG_G1_SERIAL_PORT_ONE_GATE 1
`define PCG_G1_SERIAL_PORT_ZERO_GATE 0
`define PCG_G1_MASK 32'h0107_0013
`define PCG_G2_MASK 32'h0000_001f
`define PCG_RCC_ACG 22
`define PCG_RCC_MASK 32'h0040_0000
`define PCG_FSTAT_MASK 32'h0000_0fff

// ==========================================
// reset values
`define PCG_GATE_RST 32'h0000_0000
`define PCG_RCC_RST 32'h0000_0000
`define PCG_FMASK_RST 32'h0000_0000

`endif

/* hw/pcg_pkg.sv */
// types shared by the peripheral clock gating block
package pcg_pkg;
   typedef enum logic [1:0] {PCG_MODE_RUN, PCG_MODE_SLEEP, PCG_MODE_DEEP} pcg_mode_e;
   typedef logic [31:0] pcg_word_t;
endpackage : pcg_pkg

/* hw/pcg_mode_sel.sv */
// power mode synchroniser and gating copy selector
`timescale 1ns/10ps
module pcg_mode_sel
(
   input wire logic pclk,                   // system clock
   input wire logic presetn,                // async reset, active low
   input wire logic sleep_req,              // processor sleep request pin
   input wire logic deep_req,               // processor deep sleep request pin
   input wire logic auto_clock_gating_select,                    // auto clock gating select
   output pcg_pkg::pcg_mode_e mode          // copy now in force
);
   import pcg_pkg::*;

   logic [2:0] slp_sync_q;
   logic [2:0] dsl_sync_q;
   logic slp_q;
   logic dsl_q;
   pcg_mode_e mode_q;
   pcg_mode_e mode_d;

   // ==========================================
   // three-stage pin sync; level counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slp_sync_q <= 3'h0;
         dsl_sync_q <= 3'h0;
         slp_q <= 1'b0;
         dsl_q <= 1'b0;
      end
      else
      begin
         slp_sync_q <= {slp_sync_q[1:0], sleep_req};
         dsl_sync_q <= {dsl_sync_q[1:0], deep_req};
         if (slp_sync_q[1] == slp_sync_q[2])
            slp_q <= slp_sync_q[2];
         if (dsl_sync_q[1] == dsl_sync_q[2])
            dsl_q <= dsl_sync_q[2];
      end
   end

   // ==========================================
   // selection; only run copy unless auto gating is set
   always_comb
   begin
      mode_d = PCG_MODE_RUN;
      if (auto_clock_gating_select && dsl_q)
         mode_d = PCG_MODE_DEEP;
      else if (auto_clock_gating_select && slp_q)
         mode_d = PCG_MODE_SLEEP;
   end

   // registered so the enables change only on clock edges
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_q <= PCG_MODE_RUN;
      else
         mode_q <= mode_d;
   end

   assign mode = mode_q;
endmodule : pcg_mode_sel

/* hw/pcg_top.sv */
// peripheral clock gating control with apb registers and bus fault check
// ==========================================
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`include "pcg_consts.svh"
module pcg_top
(
   input wire logic pclk,                     // system clock, 25 MHz
   input wire logic presetn,                  // async reset, active low
   input wire logic psel,                     // apb select
   input wire logic penable,                  // apb access phase
   input wire logic pwrite,                   // apb write
   input wire logic [11:0] paddr,             // apb byte address
   input wire logic [31:0] pwdata,            // apb write data
   input wire logic [3:0] pstrb,              // apb byte strobes
   output logic [31:0] prdata,                // apb read data
   output logic pready,                       // apb ready
   output logic pslverr,                      // apb error
   input wire logic sleep_req,                // processor in sleep
   input wire logic deep_req,                 // processor in deep sleep
   input wire logic [11:0] periph_access,     // peripheral access strobes, one per unit
   output logic [11:0] periph_fault,          // bus fault pulses, one per unit
   output logic comparator_zero_gate,         // comparator clock enable
   output logic general_timer_two_gate,       // timer two clock enable
   output logic general_timer_one_gate,       // timer one clock enable
   output logic general_timer_zero_gate,      // timer zero clock enable
   output logic sync_serial_zero_gate,        // serial port clock enable
   output logic serial_port_one_gate,         // uart one clock enable
   output logic serial_port_zero_gate,        // uart zero clock enable
   output logic [4:0] port_gate,              // gpio port e..a clock enables
   output logic irq                           // fault interrupt, level
);
   import pcg_pkg::*;

   // ==========================================
   // registers
   pcg_word_t run1_q;
   pcg_word_t slp1_q;
   pcg_word_t dsl1_q;
   pcg_word_t run2_q;
   pcg_word_t slp2_q;
   pcg_word_t dsl2_q;
   pcg_word_t rcc_q;
   pcg_word_t fstat_q;
   pcg_word_t fmask_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [11:0] fault_q;
   logic [11:0] en_q;
   pcg_mode_e mode;

   // ==========================================
   // apb decode
   wire wr_en = psel && penable && pwrite;
   wire rd_en = psel && penable && !pwrite;
   wire hit_run1 = (paddr == `PCG_OFF_RUN1);
   wire hit_run2 = (paddr == `PCG_OFF_RUN2);
   wire hit_slp1 = (paddr == `PCG_OFF_SLP1);
   wire hit_slp2 = (paddr == `PCG_OFF_SLP2);
   wire hit_dsl1 = (paddr == `PCG_OFF_DSL1);
   wire hit_dsl2 = (paddr == `PCG_OFF_DSL2);
   wire hit_rcc = (paddr == `PCG_OFF_RCC);
   wire hit_fstat = (paddr == `PCG_OFF_FSTAT);
   wire hit_fmask = (paddr == `PCG_OFF_FMASK);
   wire hit_any = hit_run1 | hit_run2 | hit_slp1 | hit_slp2 | hit_dsl1 | hit_dsl2
                  | hit_rcc | hit_fstat | hit_fmask;
   wire [31:0] bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

   // merge write data under byte strobes; reserved bits stay zero
   function automatic pcg_word_t merge(pcg_word_t old, pcg_word_t wd, pcg_word_t bm,
                                       pcg_word_t keep);
      merge = ((old & ~bm) | (wd & bm)) & keep;
   endfunction : merge

   wire [31:0] g1_mask = `PCG_G1_MASK;
   wire [31:0] g2_mask = `PCG_G2_MASK;

   // ==========================================
   // gating registers, all clear at reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run1_q <= `PCG_GATE_RST;
         slp1_q <= `PCG_GATE_RST;
         dsl1_q <= `PCG_GATE_RST;
         run2_q <= `PCG_GATE_RST;
         slp2_q <= `PCG_GATE_RST;
         dsl2_q <= `PCG_GATE_RST;
         rcc_q <= `PCG_RCC_RST;
         fmask_q <= `PCG_FMASK_RST;
      end
      else if (wr_en)
      begin
         if (hit_run1)
            run1_q <= merge(run1_q, pwdata, bmask, g1_mask);
         if (hit_slp1)
            slp1_q <= merge(slp1_q, pwdata, bmask, g1_mask);
         if (hit_dsl1)
            dsl1_q <= merge(dsl1_q, pwdata, bmask, g1_mask);
         if (hit_run2)
            run2_q <= merge(run2_q, pwdata, bmask, g2_mask);
         if (hit_slp2)
            slp2_q <= merge(slp2_q, pwdata, bmask, g2_mask);
         if (hit_dsl2)
            dsl2_q <= merge(dsl2_q, pwdata, bmask, g2_mask);
         if (hit_rcc)
            rcc_q <= merge(rcc_q, pwdata, bmask, `PCG_RCC_MASK);
         if (hit_fmask)
            fmask_q <= merge(fmask_q, pwdata, bmask, `PCG_FSTAT_MASK);
      end
   end

   // ==========================================
   // power mode selection
   pcg_mode_sel u_mode
   (
      .pclk(pclk),
      .presetn(presetn),
      .sleep_req(sleep_req),
      .deep_req(deep_req),
      .auto_clock_gating_select(rcc_q[`PCG_RCC_ACG]),
      .mode(mode)
   );

   // active copies, packed as {port e..a, comparator_zero_gate..serial_port_zero_gate}: bits 11:7 ports, 6:0 group one
   wire [31:0] g1_act = (mode == PCG_MODE_DEEP) ? dsl1_q :
                        (mode == PCG_MODE_SLEEP) ? slp1_q : run1_q;
   wire [31:0] g2_act = (mode == PCG_MODE_DEEP) ? dsl2_q :
                        (mode == PCG_MODE_SLEEP) ? slp2_q : run2_q;
   wire [11:0] en_d = {g2_act[4:0], g1_act[`PCG_G1_COMPARATOR_ZERO_GATE], g1_act[`PCG_G1_TMR2],
                       g1_act[`PCG_G1_TMR1], g1_act[`PCG_G1_TMR0], g1_act[`PCG_G1_SYNC_SERIAL_ZERO_GATE],
                       g1_act[`PCG_G1_SERIAL_PORT_ONE_GATE], g1_act[`PCG_G1_SERIAL_PORT_ZERO_GATE]};

   // enables from flops so a copy switch never glitches the gate cells
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         en_q <= 12'h000;
      else
         en_q <= en_d;
   end

   assign port_gate = en_q[11:7];
   assign comparator_zero_gate = en_q[6];
   assign general_timer_two_gate = en_q[5];
   assign general_timer_one_gate = en_q[4];
   assign general_timer_zero_gate = en_q[3];
   assign sync_serial_zero_gate = en_q[2];
   assign serial_port_one_gate = en_q[1];
   assign serial_port_zero_gate = en_q[0];

   // ==========================================
   // bus fault per peripheral, plus sticky status
   wire [11:0] fault_d = periph_access & ~en_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fault_q <= 12'h000;
      else
         fault_q <= fault_d;
   end

   assign periph_fault = fault_q;

   // set wins over the write-one clear
   wire [31:0] fclr = (wr_en && hit_fstat) ? (pwdata & bmask) : 32'h0000_0000;
   wire [31:0] fset = {20'h00000, fault_q};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fstat_q <= 32'h0000_0000;
      else
         fstat_q <= ((fstat_q & ~fclr) | fset) & `PCG_FSTAT_MASK;
   end

   assign irq = |(fstat_q & fmask_q);

   // ==========================================
   // read mux and answer; zero wait states, unmapped gives pslverr
   wire [31:0] rd_mux = hit_run1 ? run1_q :
                        hit_slp1 ? slp1_q :
                        hit_dsl1 ? dsl1_q :
                        hit_run2 ? run2_q :
                        hit_slp2 ? slp2_q :
                        hit_dsl2 ? dsl2_q :
                        hit_rcc ? rcc_q :
                        hit_fstat ? fstat_q :
                        hit_fmask ? fmask_q : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else if (psel && !penable)
      begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr_q <= !hit_any;
      end
   end

   assign pready = 1'b1;
   assign prdata = (rd_en) ? prdata_q : 32'h0000_0000;
   assign pslverr = psel && penable && pslverr_q;
endmodule : pcg_top

/* dv/pcg_top_sva.sv */
// checker on the ports of the clock gating block
`timescale 1ns/10ps
`include "pcg_consts.svh"
module pcg_top_sva
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset
   input wire logic psel, // apb
   input wire logic penable, // apb
   input wire logic pwrite, // apb
   input wire logic [11:0] paddr, // apb
   input wire logic [31:0] pwdata, // apb
   input wire logic [3:0] pstrb, // apb
   input wire logic [31:0] prdata, // apb
   input wire logic sleep_req, // mode pin
   input wire logic deep_req, // mode pin
   input wire logic [11:0] periph_access, // strobes
   input wire logic [11:0] periph_fault, // faults
   input wire logic comparator_zero_gate, // enable
   input wire logic general_timer_two_gate, // enable
   input wire logic general_timer_one_gate, // enable
   input wire logic general_timer_zero_gate, // enable
   input wire logic sync_serial_zero_gate, // enable
   input wire logic serial_port_one_gate, // enable
   input wire logic serial_port_zero_gate, // enable
   input wire logic [4:0] port_gate, // enables
   input wire logic irq // interrupt
);
   // =====
   // helpers
   logic [3:0] quiet_q;
   wire [11:0] en = {port_gate, comparator_zero_gate, general_timer_two_gate,
      general_timer_one_gate, general_timer_zero_gate, sync_serial_zero_gate,
      serial_port_one_gate, serial_port_zero_gate};
   wire [6:0] w1 = {pwdata[24], pwdata[18:16], pwdata[4], pwdata[1:0]};
   wire [4:0] w2 = pwdata[4:0];
   wire [11:0] fault_exp = periph_access & ~en;
   wire wr = psel & penable & pwrite;
   wire rd = psel & penable & ~pwrite;
   // run copy surely in force once the pins sat low past the synchroniser
   wire run = quiet_q > 4'h5;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         quiet_q <= 4'h0;
      else if (sleep_req | deep_req)
         quiet_q <= 4'h0;
      else if (quiet_q != 4'hf)
         quiet_q <= quiet_q + 4'h1;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =====
   // properties
   property p_fault; 1 |=> periph_fault == $past(fault_exp); endproperty
   a_fault: assert property (p_fault) else $error("fault pulse wrong");
   property p_rst; $rose(presetn) |-> en == 12'h000; endproperty
   a_rst: assert property (p_rst) else $error("enable set after reset");
   // full-word writes only; a strobed write keeps old bytes the checker cannot see
   property p_run1; wr && run && pstrb == 4'hf && paddr == `PCG_OFF_RUN1
      |-> ##3 en[6:0] == $past(w1, 3);
   endproperty
   a_run1: assert property (p_run1) else $error("group one enable");
   property p_run2; wr && run && pstrb == 4'hf && paddr == `PCG_OFF_RUN2
      |-> ##3 port_gate == $past(w2, 3);
   endproperty
   a_run2: assert property (p_run2) else $error("group two enable");
   property p_slp;
      wr && run && paddr inside {`PCG_OFF_SLP1, `PCG_OFF_SLP2, `PCG_OFF_DSL1, `PCG_OFF_DSL2}
      |-> ##2 $stable(en);
   endproperty
   a_slp: assert property (p_slp) else $error("sleep copy used in run");
   property p_rsv1; rd && paddr inside {`PCG_OFF_RUN1, `PCG_OFF_SLP1, `PCG_OFF_DSL1}
      |-> (prdata & ~`PCG_G1_MASK) == 32'h0; endproperty
   a_rsv1: assert property (p_rsv1) else $error("group one reserved bits");
   property p_rsv2; rd && paddr inside {`PCG_OFF_RUN2, `PCG_OFF_SLP2, `PCG_OFF_DSL2}
      |-> (prdata & ~`PCG_G2_MASK) == 32'h0; endproperty
   a_rsv2: assert property (p_rsv2) else $error("group two reserved bits");
   // a write at edge e shows on the enables as sampled at e+2
   property p_steady; quiet_q > 4'h8 && !$past(wr, 2) |-> $stable(en); endproperty
   a_steady: assert property (p_steady) else $error("enable moved alone");
   c_fault: cover property (periph_fault != 12'h000);
   c_irq: cover property (irq);
   c_deep: cover property (deep_req && en != 12'h000);
endmodule : pcg_top_sva

bind pcg_top pcg_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .sleep_req, .deep_req, .periph_access, .periph_fault,
   .comparator_zero_gate, .general_timer_two_gate, .general_timer_one_gate,
   .general_timer_zero_gate, .sync_serial_zero_gate, .serial_port_one_gate,
   .serial_port_zero_gate, .port_gate, .irq);

/* dv/pcg_periph_model.sv */
// peripherals that try bus accesses and collect the faults
`timescale 1ns/10ps
module pcg_periph_model
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset
   input wire logic go, // issue one access
   input wire logic [11:0] unit, // units targeted
   input wire logic [11:0] periph_fault, // faults back
   output logic [11:0] periph_access, // strobes
   output logic [11:0] seen // faults so far
);
   logic [11:0] acc_q, seen_q;
   assign periph_access = acc_q;
   assign seen = seen_q;
   // accesses go out whatever the enables say, as real masters do
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         acc_q <= 12'h000;
         seen_q <= 12'h000;
      end
      else
      begin
         acc_q <= go ? unit : 12'h000;
         seen_q <= seen_q | periph_fault;
      end
endmodule : pcg_periph_model

/* dv/pcg_top_tb_top.sv */
// self-checking bench for the clock gating block
`timescale 1ns/10ps
`include "pcg_consts.svh"
module pcg_top_tb_top;
   typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r;} pcg_row_s;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic sleep_req = 1'b0, deep_req = 1'b0, go = 1'b0, rerr;
   logic [11:0] paddr = 12'h000, unit = 12'h000;
   logic [31:0] pwdata = 32'h0, rdat;
   logic [3:0] pstrb = 4'hf;
   wire [31:0] prdata;
   wire pready, pslverr, irq, comparator_zero_gate, general_timer_two_gate;
   wire general_timer_one_gate, general_timer_zero_gate, sync_serial_zero_gate;
   wire serial_port_one_gate, serial_port_zero_gate;
   wire [4:0] port_gate;
   wire [11:0] periph_access, periph_fault, seen;
   wire [11:0] en = {port_gate, comparator_zero_gate, general_timer_two_gate,
      general_timer_one_gate, general_timer_zero_gate, sync_serial_zero_gate,
      serial_port_one_gate, serial_port_zero_gate};
   int err_count = 0, checks_done = 0, cyc = 0;
   pcg_row_s rows [8] = '{'{`PCG_OFF_RUN1, 32'hffff_ffff, `PCG_G1_MASK},
      '{`PCG_OFF_SLP1, 32'hffff_ffff, `PCG_G1_MASK}, '{`PCG_OFF_DSL1, 32'hffff_ffff, `PCG_G1_MASK},
      '{`PCG_OFF_RUN2, 32'hffff_ffff, `PCG_G2_MASK}, '{`PCG_OFF_SLP2, 32'hffff_ffff, `PCG_G2_MASK},
      '{`PCG_OFF_DSL2, 32'hffff_ffff, `PCG_G2_MASK}, '{`PCG_OFF_RCC, 32'hffff_ffff, `PCG_RCC_MASK},
      '{`PCG_OFF_FMASK, 32'hffff_ffff, `PCG_FSTAT_MASK}};
   pcg_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .sleep_req, .deep_req, .periph_access,
      .periph_fault, .comparator_zero_gate, .general_timer_two_gate, .general_timer_one_gate,
      .general_timer_zero_gate, .sync_serial_zero_gate, .serial_port_one_gate,
      .serial_port_zero_gate, .port_gate, .irq);
   pcg_periph_model u_periph (.pclk, .presetn, .go, .unit, .periph_fault, .periph_access,
      .seen);
   always #20 pclk = ~pclk;
   // =====
   // tasks
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // only the cycle ceiling ends a wait that never sees ready
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch at %0t: reg %h exp %h", $time, g, e);
      end
   endtask : chk_reg
   task automatic chk_sig(input logic [11:0] g, input logic [11:0] e);
      checks_done++;
      if (g !== e)
      begin
         err_count++;
         $display("mismatch at %0t: pins %h exp %h", $time, g, e);
      end
   endtask : chk_sig
   task automatic conclude();
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude
   task automatic wait_mode(input logic s, input logic d, input logic [11:0] e);
      sleep_req <= s;
      deep_req <= d;
      repeat (8) @(posedge pclk);
      chk_sig(en, e);
   endtask : wait_mode
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         $display("mismatch at %0t: timeout", $time);
         err_count++;
         conclude();
      end
   end
   // =====
   // sequence
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `PCG_OFF_DSL2, 32'h0);
      chk_sig({11'h0, pready}, 12'h001);
      chk_reg(rdat, `PCG_GATE_RST);
      chk_sig(en, 12'h000);
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].a, rows[i].w);
         apb(1'b0, rows[i].a, 32'h0);
         chk_reg(rdat, rows[i].r);
      end
      chk_sig(en, 12'hfff);
      apb(1'b1, `PCG_OFF_SLP1, 32'h0000_0001);
      apb(1'b1, `PCG_OFF_SLP2, 32'h0);
      apb(1'b1, `PCG_OFF_DSL1, 32'h0001_0000);
      apb(1'b1, `PCG_OFF_DSL2, 32'h0000_0001);
      wait_mode(1'b1, 1'b0, 12'h001);
      wait_mode(1'b1, 1'b1, 12'h088);
      wait_mode(1'b0, 1'b0, 12'hfff);
      apb(1'b1, `PCG_OFF_RCC, 32'h0);
      wait_mode(1'b1, 1'b0, 12'hfff);
      wait_mode(1'b0, 1'b0, 12'hfff);
      apb(1'b0, `PCG_OFF_RUN1, 32'h0);
      apb(1'b1, `PCG_OFF_RUN1, rdat & ~32'h1);
      repeat (3) @(posedge pclk);
      chk_sig(en, 12'hffe);
      // byte two only: timers cleared, comparator and serial bits keep their old bytes
      pstrb <= 4'h4;
      apb(1'b1, `PCG_OFF_RUN1, 32'h0000_0001);
      pstrb <= 4'hf;
      apb(1'b0, `PCG_OFF_RUN1, 32'h0);
      chk_reg(rdat, 32'h0100_0012);
      chk_sig(en, 12'hfc6);
      go <= 1'b1;
      unit <= 12'h003;
      @(posedge pclk);
      go <= 1'b0;
      repeat (4) @(posedge pclk);
      chk_sig(seen, 12'h001);
      apb(1'b0, `PCG_OFF_FSTAT, 32'h0);
      chk_reg(rdat, 32'h0000_0001);
      chk_sig({11'h0, irq}, 12'h001);
      apb(1'b1, `PCG_OFF_FMASK, 32'h0);
      @(posedge pclk);
      chk_sig({11'h0, irq}, 12'h000);
      apb(1'b1, `PCG_OFF_FMASK, 32'h0000_0fff);
      apb(1'b1, `PCG_OFF_FSTAT, 32'h0000_0001);
      @(posedge pclk);
      chk_sig({11'h0, irq}, 12'h000);
      apb(1'b1, 12'h300, 32'hffff_ffff);
      chk_sig({11'h0, rerr}, 12'h001);
      apb(1'b0, 12'h300, 32'h0);
      chk_reg(rdat, 32'h0);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_sig(en, 12'h000);
      conclude();
   end
endmodule : pcg_top_tb_top
